/* flash_host_ctrl.sv */
`timescale 1ns/1ns
`include "flash_host_defs.svh"
module flash_host_ctrl (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rstn,
    // User request port
    input  wire logic                    i_req,
    input  wire flash_host_pkg::op_e     i_op,
    input  wire logic [`FH_ADDR_W-1:0]   i_addr,
    input  wire logic [`FH_DATA_W-1:0]   i_wdata,
    input  wire logic                    i_unlock,
    input  wire logic                    i_abort,
    // User answer port
    output logic                         o_busy,
    output logic                         o_done,
    output logic [`FH_DATA_W-1:0]        o_rdata,
    // Flash pins
    output logic                         o_reset_powerdown_n,
    output logic                         o_ce_n,
    output logic                         o_oe_n,
    output logic                         o_we_n,
    output logic                         o_lock_guard_n,
    output logic [`FH_ADDR_W-1:0]        o_addr,
    input  wire logic [`FH_DATA_W-1:0]   i_dq,
    output logic [`FH_DATA_W-1:0]        o_dq,
    output logic                         o_dq_oe
);
    import flash_host_pkg::*;

    state_e                 state_r;
    op_e                    op_r;
    logic [1:0]             step_r;
    logic [9:0]             cnt_r;
    logic [9:0]             since_rp_r;
    logic [9:0]             low_cnt_r;
    logic                   abort_r;
    logic [`FH_DATA_W-1:0]  wdata_r;
    logic [`FH_DATA_W-1:0]  last_wr_r;
    logic [`FH_DATA_W-1:0]  dq_sync;
    kind_e                  kind;

    // ------------------------------------------------------------
    // Step decoding
    // ------------------------------------------------------------

    // Kind of bus cycle for a given operation and step
    function automatic kind_e step_kind(input op_e op, input logic [1:0] step);
        kind_e k;
        k = K_END;
        unique case (op)
            OP_READ:               k = (step == 2'h0) ? K_READ : K_END;
            OP_WRITE:              k = (step == 2'h0) ? K_WRITE : K_END;
            OP_PROGRAM, OP_ERASE:  k = (step == 2'h2) ? K_POLL : K_WRITE;
            OP_RESET:              k = K_END;
        endcase
        return k;
    endfunction : step_kind

    // Data word driven in a write step
    function automatic logic [`FH_DATA_W-1:0] step_data(input op_e op, input logic [1:0] step,
                                                      input logic [`FH_DATA_W-1:0] wd);
        logic [`FH_DATA_W-1:0] d;
        d = wd;
        if (step == 2'h3)
            d = `FH_CMD_READ_ARRAY;
        else if (op == OP_PROGRAM)
            d = (step == 2'h0) ? `FH_CMD_PROGRAM : wd;
        else if (op == OP_ERASE)
            d = (step == 2'h0) ? `FH_CMD_ERASE : `FH_CMD_CONFIRM;
        return d;
    endfunction : step_data

    assign kind = step_kind(op_r, step_r);

    // ------------------------------------------------------------
    // Data pin input chain
    // ------------------------------------------------------------

    flash_host_sync #(.W(`FH_DATA_W)) u_dq_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_pin  (i_dq),
        .o_val  (dq_sync)
    );

    // ------------------------------------------------------------
    // Reset pin timers
    // ------------------------------------------------------------

    // Cycles since reset pin rose, and length of current low phase
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            since_rp_r <= 10'h000;
            low_cnt_r  <= 10'h000;
        end
        else if (!o_reset_powerdown_n)
        begin
            since_rp_r <= 10'h000;
            low_cnt_r  <= (low_cnt_r == `FH_CNT_MAX) ? low_cnt_r : low_cnt_r + 10'h001;
        end
        else
        begin
            since_rp_r <= (since_rp_r == `FH_CNT_MAX) ? since_rp_r : since_rp_r + 10'h001;
            low_cnt_r  <= 10'h000;
        end
    end

    // ------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------

    // States, pins and answers; system reset holds the flash in reset
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r             <= ST_RST_LOW;
            op_r                <= OP_READ;
            step_r              <= 2'h0;
            cnt_r               <= 10'h000;
            abort_r             <= 1'b0;
            wdata_r             <= 16'h0000;
            last_wr_r           <= 16'h0000;
            o_reset_powerdown_n <= 1'b0;
            o_ce_n              <= 1'b1;
            o_oe_n              <= 1'b1;
            o_we_n              <= 1'b1;
            o_lock_guard_n      <= 1'b0;
            o_addr              <= '0;
            o_dq                <= 16'h0000;
            o_dq_oe             <= 1'b0;
            o_busy              <= 1'b1;
            o_done              <= 1'b0;
            o_rdata             <= 16'h0000;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_abort && state_r != ST_RST_LOW)
            begin
                // Abort: pull reset, stretch low time if flash may be busy
                abort_r             <= (op_r == OP_PROGRAM || op_r == OP_ERASE);
                op_r                <= OP_RESET;
                state_r             <= ST_RST_LOW;
                cnt_r               <= 10'h000;
                o_reset_powerdown_n <= 1'b0;
                o_ce_n              <= 1'b1;
                o_oe_n              <= 1'b1;
                o_we_n              <= 1'b1;
                o_dq_oe             <= 1'b0;
                o_lock_guard_n      <= 1'b0;
                o_busy              <= 1'b1;
            end
            else
            begin
                unique case (state_r)
                    ST_RST_LOW:
                    begin
                        cnt_r <= cnt_r + 10'h001;
                        if (cnt_r + 10'h001 >= (abort_r ? `FH_SHUT_CYC : `FH_PULSE_CYC))
                        begin
                            o_reset_powerdown_n <= 1'b1;
                            o_done              <= (op_r == OP_RESET);
                            o_busy              <= 1'b0;
                            state_r             <= ST_IDLE;
                        end
                    end
                    ST_IDLE:
                    begin
                        if (i_req)
                        begin
                            op_r           <= i_op;
                            step_r         <= 2'h0;
                            cnt_r          <= 10'h000;
                            abort_r        <= 1'b0;
                            wdata_r        <= i_wdata;
                            o_addr         <= i_addr;
                            o_lock_guard_n <= i_unlock;
                            o_busy         <= 1'b1;
                            if (i_op == OP_RESET)
                            begin
                                o_reset_powerdown_n <= 1'b0;
                                state_r             <= ST_RST_LOW;
                            end
                            else
                                state_r <= ST_ISSUE;
                        end
                    end
                    ST_ISSUE:
                    begin
                        unique case (kind)
                            K_END:
                            begin
                                o_done         <= 1'b1;
                                o_busy         <= 1'b0;
                                o_lock_guard_n <= 1'b0;
                                state_r        <= ST_IDLE;
                            end
                            K_WRITE:
                            begin
                                if (since_rp_r >= `FH_WRITE_CYC && since_rp_r >= `FH_SELECT_CYC)
                                begin
                                    o_ce_n    <= 1'b0;
                                    o_dq      <= step_data(op_r, step_r, wdata_r);
                                    last_wr_r <= step_data(op_r, step_r, wdata_r);
                                    o_dq_oe   <= 1'b1;
                                    state_r   <= ST_WR_SETUP;
                                end
                            end
                            K_READ, K_POLL:
                            begin
                                if (since_rp_r >= `FH_OUTPUT_CYC)
                                begin
                                    o_ce_n  <= 1'b0;
                                    o_oe_n  <= 1'b0;
                                    cnt_r   <= 10'h000;
                                    state_r <= ST_RD_WAIT;
                                end
                            end
                        endcase
                    end
                    ST_WR_SETUP:
                    begin
                        o_we_n  <= 1'b0;
                        cnt_r   <= 10'h000;
                        state_r <= ST_WR_PULSE;
                    end
                    ST_WR_PULSE:
                    begin
                        cnt_r <= cnt_r + 10'h001;
                        if (cnt_r + 10'h001 >= `FH_WP_CYC)
                        begin
                            o_we_n  <= 1'b1;
                            state_r <= ST_WR_HOLD;
                        end
                    end
                    ST_WR_HOLD:
                    begin
                        o_ce_n  <= 1'b1;
                        o_dq_oe <= 1'b0;
                        if (step_r == 2'h3)
                        begin
                            // Read-array write closes the op; two-bit step would wrap
                            o_done         <= 1'b1;
                            o_busy         <= 1'b0;
                            o_lock_guard_n <= 1'b0;
                            state_r        <= ST_IDLE;
                        end
                        else
                        begin
                            step_r  <= step_r + 2'h1;
                            state_r <= ST_GAP;
                        end
                    end
                    ST_RD_WAIT:
                    begin
                        cnt_r <= cnt_r + 10'h001;
                        if (cnt_r + 10'h001 >= `FH_READ_CYC)
                        begin
                            o_ce_n  <= 1'b1;
                            o_oe_n  <= 1'b1;
                            o_rdata <= dq_sync;
                            if (kind != K_POLL || dq_sync[`FH_SR_READY])
                                step_r <= step_r + 2'h1;
                            state_r <= ST_GAP;
                        end
                    end
                    ST_GAP:
                        state_r <= ST_ISSUE;
                    default:
                        state_r <= ST_RST_LOW;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    property p_write_after_reset;
        @(posedge i_clk) disable iff (!i_rstn)
        $fell(o_we_n) |-> since_rp_r >= `FH_WRITE_CYC && since_rp_r >= `FH_SELECT_CYC;
    endproperty
    a_write_after_reset: assert property (p_write_after_reset)
        else $error("write strobe too soon after reset release");

    property p_read_after_reset;
        @(posedge i_clk) disable iff (!i_rstn)
        $fell(o_oe_n) |-> since_rp_r >= `FH_OUTPUT_CYC;
    endproperty
    a_read_after_reset: assert property (p_read_after_reset)
        else $error("read too soon after reset release");

    property p_reset_low_time;
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(o_reset_powerdown_n) |-> low_cnt_r >= `FH_PULSE_CYC;
    endproperty
    a_reset_low_time: assert property (p_reset_low_time)
        else $error("reset pulse shorter than minimum");

    property p_abort_shutdown;
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(o_reset_powerdown_n) && abort_r |-> low_cnt_r >= `FH_SHUT_CYC;
    endproperty
    a_abort_shutdown: assert property (p_abort_shutdown)
        else $error("reset released before abort shutdown ended");

    property p_write_encoding;
        @(posedge i_clk) disable iff (!i_rstn)
        !o_we_n |-> o_oe_n && !o_ce_n && o_reset_powerdown_n && o_dq_oe;
    endproperty
    a_write_encoding: assert property (p_write_encoding)
        else $error("write strobe with bad control levels");

    property p_no_contention;
        @(posedge i_clk) disable iff (!i_rstn)
        o_dq_oe |-> o_oe_n;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("host drives data while flash outputs enabled");

    property p_latch_stable;
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(o_we_n) && o_reset_powerdown_n |-> $stable(o_addr) && $stable(o_dq) && !o_ce_n
            ##1 o_ce_n;
    endproperty
    a_latch_stable: assert property (p_latch_stable)
        else $error("address or data moved at strobe rise");

    property p_lock_held;
        @(posedge i_clk) disable iff (!i_rstn)
        (op_r == OP_PROGRAM || op_r == OP_ERASE) && state_r != ST_IDLE
            && $past(state_r) != ST_IDLE && state_r != ST_RST_LOW |-> $stable(o_lock_guard_n);
    endproperty
    a_lock_held: assert property (p_lock_held)
        else $error("lock guard changed during program or erase");

    property p_array_restore;
        @(posedge i_clk) disable iff (!i_rstn)
        o_done && (op_r == OP_PROGRAM || op_r == OP_ERASE)
            |-> last_wr_r == `FH_CMD_READ_ARRAY && o_we_n;
    endproperty
    a_array_restore: assert property (p_array_restore)
        else $error("program or erase ended without read-array command");

endmodule : flash_host_ctrl

/* flash_host_defs.svh */
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// Clock and timing, times in ns
`define FH_CLK_NS               40
`define FH_T_RESET_PULSE_NS     100
`define FH_T_RESET_OUTPUT_NS    150
`define FH_T_RESET_WRITE_NS     150
`define FH_T_RESET_SELECT_NS    150
`define FH_T_ABORT_SHUTDOWN_NS  20000
`define FH_T_ACCESS_NS          110
`define FH_T_WRITE_PULSE_NS     70
`define FH_CYC_MIN(ns)          (((ns) + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_SYNC_CYC             4
`define FH_PULSE_CYC            10'(`FH_CYC_MIN(`FH_T_RESET_PULSE_NS))
`define FH_OUTPUT_CYC           10'(`FH_CYC_MIN(`FH_T_RESET_OUTPUT_NS))
`define FH_WRITE_CYC            10'(`FH_CYC_MIN(`FH_T_RESET_WRITE_NS))
`define FH_SELECT_CYC           10'(`FH_CYC_MIN(`FH_T_RESET_SELECT_NS))
`define FH_SHUT_CYC             10'(`FH_CYC_MIN(`FH_T_ABORT_SHUTDOWN_NS))
`define FH_READ_CYC             10'(`FH_CYC_MIN(`FH_T_ACCESS_NS) + `FH_SYNC_CYC)
`define FH_WP_CYC               10'(`FH_CYC_MIN(`FH_T_WRITE_PULSE_NS))
`define FH_CNT_MAX              10'h3FF

// Command codes
`define FH_CMD_PROGRAM          16'h0040
`define FH_CMD_ERASE            16'h0020
`define FH_CMD_CONFIRM          16'h00D0
`define FH_CMD_READ_ARRAY       16'h00FF
`define FH_CMD_READ_STATUS      16'h0070

// Status fields and widths
`define FH_SR_READY             7
`define FH_SR_ERASE_FAIL        5
`define FH_SR_PROGRAM_FAIL      4
`define FH_SR_LOCK_FAIL         1
`define FH_ADDR_W               22
`define FH_DATA_W               16
`endif

/* flash_host_pkg.sv */
package flash_host_pkg;

    // Operations requested by the user side
    typedef enum logic [2:0]
    {
        OP_READ    = 3'h0,
        OP_WRITE   = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_ERASE   = 3'h3,
        OP_RESET   = 3'h4
    } op_e;

    // Bus sequencer states, one-hot
    typedef enum logic [7:0]
    {
        ST_RST_LOW  = 8'h01,
        ST_IDLE     = 8'h02,
        ST_ISSUE    = 8'h04,
        ST_WR_SETUP = 8'h08,
        ST_WR_PULSE = 8'h10,
        ST_WR_HOLD  = 8'h20,
        ST_RD_WAIT  = 8'h40,
        ST_GAP      = 8'h80
    } state_e;

    // Kind of bus cycle a step performs
    typedef enum logic [1:0]
    {
        K_WRITE = 2'h0,
        K_READ  = 2'h1,
        K_POLL  = 2'h2,
        K_END   = 2'h3
    } kind_e;

endpackage : flash_host_pkg

/* flash_host_sync.sv */
`timescale 1ns/1ns
module flash_host_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Pin side and result
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_val
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Three-stage chain; value taken once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            o_val <= '0;
        end
        else
        begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                o_val <= s3_r;
        end
    end
endmodule : flash_host_sync

/* flash_model.sv */
`timescale 1ns/1ns
module flash_model #(
    parameter int          PROG_NS  = 2000,
    parameter int          ERASE_NS = 8000,
    parameter logic [15:0] MAKER_ID = 16'h00A5, // Arbitrary value
    parameter logic [15:0] PART_ID  = 16'h005A  // Arbitrary value
) (
    // Flash pins
    input  wire logic        i_reset_powerdown_n,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_lock_guard_n,
    input  wire logic [21:0] i_addr,
    input  wire logic [15:0] i_dq,
    output logic      [15:0] o_dq
);
    logic [15:0] mem [int];
    logic [7:0]  sr;
    logic [7:0]  pend;
    logic        supply_ok = 1'b1; // Program supply above lockout level
    logic [21:0] pa;
    int          mode;
    time         done_t;
    wire         wr_act = i_reset_powerdown_n & ~i_ce_n & ~i_we_n & i_oe_n;

    // Block index: eight small blocks, then large ones
    function automatic int blk(input logic [21:0] a);
        return (a < 22'h008000) ? int'(a >> 12) : int'((a - 22'h008000) >> 15) + 8;
    endfunction : blk

    // Word for current read mode
    function automatic logic [15:0] rd(input logic [21:0] a, input logic c, input logic o);
        if (mode == 1)
            return {8'h00, sr | (($time < done_t) ? 8'h00 : 8'h80)};
        if (mode == 2)
            return (a[21:1] == 21'h0) ? (a[0] ? PART_ID : MAKER_ID) : 16'h0000;
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
    endfunction : rd

    // Read word in a read cycle, else the same word inverted
    assign o_dq = (i_reset_powerdown_n && !i_ce_n && !i_oe_n && i_we_n) ?
                  rd(i_addr, i_ce_n, i_oe_n) : ~rd(i_addr, i_ce_n, i_oe_n);

    // Reset pin low aborts and returns to array reads
    initial mode = 0;
    initial sr = 8'h00;
    initial pend = 8'h00;
    initial done_t = 0;
    always @(negedge i_reset_powerdown_n)
    begin
        if ($time < done_t) mem[int'(pa)] = 16'h5A5A;
        mode   = 0;
        sr     = 8'h00;
        pend   = 8'h00;
        done_t = 0;
    end

    // Command latch at the end of a write cycle
    always @(negedge wr_act)
    begin
        if (i_reset_powerdown_n && pend == 8'h40)
        begin
            pa = i_addr;
            if (supply_ok && (i_lock_guard_n || i_addr >= 22'h002000))
                mem[int'(i_addr)] = i_dq;
            else if (supply_ok) sr = sr | 8'h12;
            done_t = $time + PROG_NS;
            mode = 1;
            pend = 8'h00;
        end
        else if (i_reset_powerdown_n && pend == 8'h20)
        begin
            if (i_dq[7:0] != 8'hD0) sr = sr | 8'h30;
            else if (!i_lock_guard_n && i_addr < 22'h002000) sr = sr | 8'h22;
            else if (supply_ok)
                foreach (mem[k]) if (blk(22'(k)) == blk(i_addr)) mem[k] = 16'hFFFF;
            done_t = $time + ERASE_NS;
            mode = 1;
            pend = 8'h00;
        end
        else if (i_reset_powerdown_n)
        begin
            pend = (i_dq[7:0] == 8'h40 || i_dq[7:0] == 8'h20) ? i_dq[7:0] : 8'h00;
            if (i_dq[7:0] == 8'hFF) mode = 0;
            if (i_dq[7:0] == 8'h70) mode = 1;
            if (i_dq[7:0] == 8'h90) mode = 2;
        end
    end
endmodule : flash_model

/* tb.sv */
`timescale 1ns/1ns
module tb;
    import flash_host_pkg::*;
    logic        i_clk, i_rstn, i_req, i_unlock, i_abort;
    op_e         i_op;
    logic [21:0] i_addr, f_addr, a;
    logic [15:0] i_wdata, o_rdata, dq_out, fm_q, d;
    logic        o_busy, o_done, rp_n, ce_n, oe_n, we_n, lock_n, dq_oe;
    wire  [15:0] dq_bus = dq_oe ? dq_out : fm_q;
    logic [15:0] ref_mem [int];
    logic [7:0]  ref_sr;
    int          bad_count, total_checks, cyc;

    // Device under test and flash model
    flash_host_ctrl u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_op(i_op),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_unlock(i_unlock), .i_abort(i_abort),
        .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_reset_powerdown_n(rp_n),
        .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_lock_guard_n(lock_n),
        .o_addr(f_addr), .i_dq(dq_bus), .o_dq(dq_out), .o_dq_oe(dq_oe));
    flash_model u_fm (.i_reset_powerdown_n(rp_n), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_lock_guard_n(lock_n), .i_addr(f_addr), .i_dq(dq_bus), .o_dq(fm_q));

    // Clock and hang guard
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            test_done();
        end
    end

    // Reference helpers
    function automatic int blk(input logic [21:0] x);
        return (x < 22'h008000) ? int'(x >> 12) : int'((x - 22'h008000) >> 15) + 8;
    endfunction : blk
    function automatic logic [15:0] exp_rd(input logic [21:0] x);
        return ref_mem.exists(int'(x)) ? ref_mem[int'(x)] : 16'hFFFF;
    endfunction : exp_rd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One user request, optional abort after ab cycles
    task automatic run(input op_e op, input logic [21:0] x, input logic [15:0] w,
                       input logic un, input int ab);
        @(negedge i_clk);
        i_op = op;
        i_addr = x;
        i_wdata = w;
        i_unlock = un;
        i_req = 1'b1;
        @(negedge i_clk);
        i_req = 1'b0;
        repeat (ab) @(negedge i_clk);
        i_abort = (ab > 0);
        @(negedge i_clk);
        i_abort = 1'b0;
        while (o_done !== 1'b1) @(negedge i_clk);
    endtask : run

    task automatic rd_chk(input logic [21:0] x, input logic [15:0] exp);
        run(OP_READ, x, 16'h0000, 1'b0, 0);
        chk(o_rdata, exp);
    endtask : rd_chk

    task automatic test_done;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // Main sequence
    initial
    begin
        i_clk = 0; i_rstn = 0; i_req = 0; i_op = OP_READ; i_addr = 0; i_wdata = 0;
        i_unlock = 0; i_abort = 0; ref_sr = 0; bad_count = 0; total_checks = 0; cyc = 0;
        d = 16'($urandom(32'hA37A));
        repeat (5) @(negedge i_clk);
        i_rstn = 1;
        while (o_busy !== 1'b0) @(negedge i_clk);
        rd_chk(22'h000100, 16'hFFFF);
        // Programs: locked and unlocked small blocks, large blocks
        for (int i = 0; i < 6; i++)
        begin
            a = (i < 2) ? 22'($urandom_range(0, 8191)) : 22'($urandom_range(8192, 22'h3FFFFF));
            d = 16'($urandom);
            run(OP_PROGRAM, a, d, i[0], 0);
            if (a < 22'h002000 && !i[0]) ref_sr = ref_sr | 8'h12;
            else ref_mem[int'(a)] = d;
            chk(o_rdata, {8'h00, 8'h80 | ref_sr});
            rd_chk(a, exp_rd(a));
        end
        // Erase one large block and a locked small one
        run(OP_PROGRAM, 22'h010004, 16'h1234, 1'b1, 0);
        run(OP_PROGRAM, 22'h018004, 16'h4321, 1'b1, 0);
        run(OP_ERASE, 22'h010000, 16'h0000, 1'b1, 0);
        run(OP_ERASE, 22'h000100, 16'h0000, 1'b0, 0);
        // Program with supply locked out must leave the array alone
        u_fm.supply_ok = 1'b0;
        run(OP_PROGRAM, 22'h018004, 16'h0F0F, 1'b1, 0);
        u_fm.supply_ok = 1'b1;
        ref_mem[int'(22'h018004)] = 16'h4321;
        foreach (ref_mem[k]) if (blk(22'(k)) == blk(22'h010000)) ref_mem[k] = 16'hFFFF;
        ref_sr = ref_sr | 8'h22;
        chk(o_rdata, {8'h00, 8'h80 | ref_sr});
        rd_chk(22'h010004, 16'hFFFF);
        rd_chk(22'h018004, 16'h4321);
        // Pin reset, then each read mode by raw command
        run(OP_RESET, 22'h000000, 16'h0000, 1'b0, 0);
        run(OP_WRITE, 22'h000000, 16'h0070, 1'b0, 0);
        rd_chk(22'h01234A, 16'h0080);
        run(OP_WRITE, 22'h000000, 16'h0090, 1'b0, 0);
        rd_chk(22'h000000, u_fm.MAKER_ID);
        run(OP_WRITE, 22'h000000, 16'h00FF, 1'b0, 0);
        rd_chk(22'h018004, 16'h4321);
        // Abort a running program
        run(OP_PROGRAM, 22'h020008, 16'hBEEF, 1'b1, 30);
        rd_chk(22'h018004, 16'h4321);
        run(OP_WRITE, 22'h000000, 16'h0070, 1'b0, 0);
        rd_chk(22'h000000, 16'h0080);
        test_done();
    end
endmodule : tb
